// ===== rtl/smg_pkg.sv
// Package with constants and types of the strap mode select and GPIO role block.
package smg_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int         CLK_HZ        = 10_000_000;
	localparam int         BCLK_HZ       = 12_288_000;
	localparam int         BCLK_HALF_RAW = CLK_HZ / (2 * BCLK_HZ);
	localparam logic [3:0] BCLK_HALF_CNT = (BCLK_HALF_RAW > 0) ? 4'(BCLK_HALF_RAW) : 4'h1;

	// ------------------------------------------------------------------
	// Pin positions and reset values
	// ------------------------------------------------------------------
	localparam int         GPIO_W    = 8;
	localparam int         MIC_PIN   = 1;
	localparam int         STRAP_LO  = 2;
	localparam int         STRAP_HI  = 3;
	localparam int         MON_PIN   = 4;
	localparam logic [7:0] PU_RST    = 8'hFF;
	localparam logic [7:0] OE_RST    = 8'h00;

	// ------------------------------------------------------------------
	// Slot layout
	// ------------------------------------------------------------------
	localparam logic [3:0] SLOT_DEFAULT = 4'h5;
	localparam logic [3:0] SLOT_ALT_A   = 4'hA;
	localparam logic [3:0] SLOT_ALT_B   = 4'hB;
	localparam logic [3:0] SLOT_LAST    = 4'hC;
	localparam logic [4:0] TAG_BITS     = 5'h10;
	localparam logic [4:0] SLOT_BITS    = 5'h14;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DSP      = 2'b00,
		MODE_SEC_ID10 = 2'b01,
		MODE_SEC_ID01 = 2'b10,
		MODE_PRI      = 2'b11
	} smg_mode_t;

	typedef enum logic {
		LCH_WAIT   = 1'b0,
		LCH_LOCKED = 1'b1
	} smg_latch_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} smg_gpio_pads_t;

	typedef struct packed {
		logic bclk_out;
		logic bclk_oe;
		logic sync_out;
		logic sync_oe;
	} smg_link_pads_t;

endpackage : smg_pkg

// ===== rtl/smg_sync2.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/100ps
module smg_sync2 #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// Levels.
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule : smg_sync2

// ===== rtl/smg_slot_track.sv
// Follows the slots of a link frame and flags the chosen sample slot.
`timescale 1ns/100ps
module smg_slot_track (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Link events.
	input  wire logic       bclk_rise_i,
	input  wire logic       frame_start_i,
	input  wire logic [3:0] slot_sel_i,
	// Result.
	output logic            slot_hit_o
);
	import smg_pkg::*;

	logic       running;
	logic [4:0] bit_cnt;
	logic [3:0] slot;
	logic       next_running;
	logic [4:0] next_bit_cnt;
	logic [3:0] next_slot;
	logic [4:0] slot_len;

	always_comb begin
		next_running = running;
		next_bit_cnt = bit_cnt;
		next_slot    = slot;
		slot_len     = (slot == 4'h0) ? TAG_BITS : SLOT_BITS;
		if (frame_start_i) begin
			next_running = 1'b1;
			next_bit_cnt = 5'h00;
			next_slot    = 4'h0;
		end else if (running && bclk_rise_i) begin
			if (bit_cnt == slot_len - 5'h01) begin
				next_bit_cnt = 5'h00;
				next_slot    = slot + 4'h1;
				if (slot == SLOT_LAST) begin
					next_running = 1'b0;
				end
			end else begin
				next_bit_cnt = bit_cnt + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			running    <= 1'b0;
			bit_cnt    <= 5'h00;
			slot       <= 4'h0;
			slot_hit_o <= 1'b0;
		end else begin
			running    <= next_running;
			bit_cnt    <= next_bit_cnt;
			slot       <= next_slot;
			slot_hit_o <= next_running && (next_slot == slot_sel_i);
		end
	end

endmodule : smg_slot_track

// ===== rtl/smg_top.sv
// Strap mode latch, GPIO role multiplexer and link pin direction control.
// ---------------------------------------------------------------------------
// Functional notes
// - After power-up every GPIO pin is an input with its pull-up on.
// - Strap pins are captured at the first rising edge of the reset pin.
// - The captured mode never changes until power is removed.
// - Straps high-high primary ID 00, high-low ID 01, low-high ID 10, low-low DSP.
// - Unconnected straps read high through pull-ups, giving primary mode.
// - After first release the strap pins act as GPIO or alternate roles.
// - Mode capture needs no crystal clock, only the reset pin edge.
// - With wake role on, wake pin goes high when any chosen pin matches its level.
// - Three select bits move pins to wake, monitor and microphone roles.
// - Sample data uses slot 5 by default, or slot 10 or 11.
// - Primary mode drives the bit clock, accepts sync, needs the crystal.
// - Secondary modes take bit clock and sync from the controller.
// - Frame sync pin is an output in DSP mode, input in link modes.
// ---------------------------------------------------------------------------
`timescale 1ns/100ps
module smg_top (
	// Clock and power-on reset.
	input  wire logic                     clk_i,
	input  wire logic                     rst_b_i,
	// External reset pin, active low.
	input  wire logic                     reset_pin_b_i,
	// GPIO pins and their configuration.
	input  wire logic [7:0]               gpio_in_i,
	input  wire logic [7:0]               gpio_dir_i,
	input  wire logic [7:0]               gpio_data_i,
	input  wire logic [7:0]               gpio_pu_en_i,
	input  wire logic [7:0]               wake_mask_i,
	input  wire logic [7:0]               wake_level_i,
	// Role selects.
	input  wire logic                     wake_role_select_i,
	input  wire logic                     monitor_role_select_i,
	input  wire logic                     mic_role_select_i,
	input  wire logic                     monitor_out_i,
	// Link configuration and pins.
	input  wire logic [1:0]               slot_delay_cfg_i,
	input  wire logic                     crystal_in_ok_i,
	input  wire logic                     bit_clk_i,
	input  wire logic                     sync_i,
	// Pads.
	output smg_pkg::smg_gpio_pads_t       gpio_pads_o,
	output smg_pkg::smg_link_pads_t       link_pads_o,
	// Status.
	output logic [7:0]                    gpio_read_o,
	output smg_pkg::smg_mode_t            mode_o,
	output logic                          mode_valid_o,
	output logic [1:0]                    codec_id_o,
	output logic                          mic_analog_in_en_o,
	output logic                          crystal_needed_o,
	output logic [3:0]                    slot_sel_o,
	output logic                          slot_hit_o
);
	import smg_pkg::*;

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	logic [7:0] gpio_s;
	logic [3:0] ctl_s;
	logic       rpin_s;
	logic       xtal_s;
	logic       bclk_pin_s;
	logic       sync_pin_s;

	smg_sync2 #(.W(8)) u_sync_gpio (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (gpio_in_i),
		.q_o     (gpio_s)
	);

	smg_sync2 #(.W(4)) u_sync_ctl (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     ({reset_pin_b_i, crystal_in_ok_i, bit_clk_i, sync_i}),
		.q_o     (ctl_s)
	);

	assign rpin_s     = ctl_s[3];
	assign xtal_s     = ctl_s[2];
	assign bclk_pin_s = ctl_s[1];
	assign sync_pin_s = ctl_s[0];

	// ------------------------------------------------------------------
	// Mode latch
	// ------------------------------------------------------------------
	function automatic logic [1:0] id_of(input smg_mode_t m);
		case (m)
			MODE_SEC_ID01: id_of = 2'b01;
			MODE_SEC_ID10: id_of = 2'b10;
			default:       id_of = 2'b00;
		endcase
	endfunction : id_of

	smg_latch_t latch_st;
	smg_latch_t next_latch_st;
	smg_mode_t  next_mode;
	logic       rpin_q;
	logic       rst_edge;

	assign rst_edge = rpin_s && !rpin_q;

	always_comb begin
		next_latch_st = latch_st;
		next_mode     = mode_o;
		case (latch_st)
			LCH_WAIT: begin
				if (rst_edge) begin
					next_mode     = smg_mode_t'(gpio_s[STRAP_HI:STRAP_LO]);
					next_latch_st = LCH_LOCKED;
				end
			end
			LCH_LOCKED: begin
				next_latch_st = LCH_LOCKED;
			end
			default: begin
				next_latch_st = LCH_WAIT;
			end
		endcase
	end

	// Only the power-on reset clears the latch.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			latch_st     <= LCH_WAIT;
			mode_o       <= MODE_PRI;
			mode_valid_o <= 1'b0;
			codec_id_o   <= 2'b00;
			rpin_q       <= 1'b0;
		end else begin
			latch_st     <= next_latch_st;
			mode_o       <= next_mode;
			mode_valid_o <= (next_latch_st == LCH_LOCKED);
			codec_id_o   <= id_of(next_mode);
			rpin_q       <= rpin_s;
		end
	end

	// ------------------------------------------------------------------
	// GPIO roles
	// ------------------------------------------------------------------
	logic           locked;
	logic           wake_hit;
	smg_gpio_pads_t next_pads;
	logic [7:0]     next_read;

	assign locked   = (latch_st == LCH_LOCKED);
	assign wake_hit = |(wake_mask_i & ~(gpio_s ^ wake_level_i));

	always_comb begin
		next_pads.out = gpio_data_i;
		next_pads.oe  = gpio_dir_i;
		next_pads.pu  = gpio_pu_en_i;
		next_read     = gpio_s;
		if (!locked) begin
			next_pads.oe = OE_RST;
			next_pads.pu = PU_RST;
		end else begin
			if (wake_role_select_i) begin
				next_pads.out[STRAP_HI] = wake_hit;
				next_pads.oe[STRAP_HI]  = 1'b1;
			end
			if (monitor_role_select_i) begin
				next_pads.out[MON_PIN] = monitor_out_i;
				next_pads.oe[MON_PIN]  = 1'b1;
			end
			if (mic_role_select_i) begin
				next_pads.out[MIC_PIN] = 1'b0;
				next_pads.oe[MIC_PIN]  = 1'b0;
				next_pads.pu[MIC_PIN]  = 1'b0;
				next_read[MIC_PIN]     = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gpio_pads_o.out    <= 8'h00;
			gpio_pads_o.oe     <= OE_RST;
			gpio_pads_o.pu     <= PU_RST;
			gpio_read_o        <= 8'h00;
			mic_analog_in_en_o <= 1'b0;
		end else begin
			gpio_pads_o        <= next_pads;
			gpio_read_o        <= next_read;
			mic_analog_in_en_o <= locked && mic_role_select_i;
		end
	end

	// ------------------------------------------------------------------
	// Link pins and bit clock
	// ------------------------------------------------------------------
	logic       drive_bclk;
	logic       bclk_gen;
	logic [3:0] bclk_cnt;
	logic       next_bclk_gen;
	logic [3:0] next_bclk_cnt;
	logic       bclk_lvl;
	logic       bclk_lvl_q;
	logic       sync_q;
	logic [3:0] next_slot_sel;

	assign drive_bclk = locked && (mode_o == MODE_PRI || mode_o == MODE_DSP) && xtal_s;
	assign bclk_lvl   = drive_bclk ? bclk_gen : bclk_pin_s;

	always_comb begin
		next_bclk_gen = bclk_gen;
		next_bclk_cnt = bclk_cnt + 4'h1;
		if (!drive_bclk) begin
			next_bclk_gen = 1'b0;
			next_bclk_cnt = 4'h0;
		end else if (bclk_cnt == BCLK_HALF_CNT - 4'h1) begin
			next_bclk_gen = !bclk_gen;
			next_bclk_cnt = 4'h0;
		end
		case (slot_delay_cfg_i)
			2'b01:   next_slot_sel = SLOT_ALT_A;
			2'b10:   next_slot_sel = SLOT_ALT_B;
			default: next_slot_sel = SLOT_DEFAULT;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bclk_gen         <= 1'b0;
			bclk_cnt         <= 4'h0;
			bclk_lvl_q       <= 1'b0;
			sync_q           <= 1'b0;
			slot_sel_o       <= SLOT_DEFAULT;
			link_pads_o      <= '0;
			crystal_needed_o <= 1'b0;
		end else begin
			bclk_gen             <= next_bclk_gen;
			bclk_cnt             <= next_bclk_cnt;
			bclk_lvl_q           <= bclk_lvl;
			sync_q               <= sync_pin_s;
			slot_sel_o           <= next_slot_sel;
			link_pads_o.bclk_out <= next_bclk_gen;
			link_pads_o.bclk_oe  <= drive_bclk;
			link_pads_o.sync_out <= 1'b0;
			link_pads_o.sync_oe  <= locked && (mode_o == MODE_DSP);
			crystal_needed_o     <= locked && (mode_o == MODE_PRI || mode_o == MODE_DSP
				|| wake_role_select_i);
		end
	end

	smg_slot_track u_slot (
		.clk_i         (clk_i),
		.rst_b_i       (rst_b_i),
		.bclk_rise_i   (bclk_lvl && !bclk_lvl_q),
		.frame_start_i (sync_pin_s && !sync_q && locked && mode_o != MODE_DSP),
		.slot_sel_i    (slot_sel_o),
		.slot_hit_o    (slot_hit_o)
	);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_pull_default;
		!mode_valid_o |-> gpio_pads_o.pu == PU_RST && gpio_pads_o.oe == OE_RST;
	endproperty
	a_pull_default: assert property (p_pull_default) else $error("GPIO not input with pull-up.");

	property p_capture;
		(latch_st == LCH_WAIT) && rst_edge |=> mode_valid_o
			&& mode_o == smg_mode_t'($past(gpio_s[STRAP_HI:STRAP_LO]));
	endproperty
	a_capture: assert property (p_capture) else $error("Strap capture wrong.");

	property p_mode_hold;
		mode_valid_o |=> mode_valid_o && $stable(mode_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("Latched mode changed.");

	property p_encode;
		mode_valid_o |-> codec_id_o == ((mode_o == MODE_SEC_ID01) ? 2'b01
			: (mode_o == MODE_SEC_ID10) ? 2'b10 : 2'b00);
	endproperty
	a_encode: assert property (p_encode) else $error("Codec ID mismatch.");

	property p_floating_primary;
		(latch_st == LCH_WAIT) && rst_edge && gpio_s[STRAP_HI:STRAP_LO] == 2'b11
			|=> mode_o == MODE_PRI && codec_id_o == 2'b00;
	endproperty
	a_floating_primary: assert property (p_floating_primary) else $error("Not primary.");

	property p_no_edge_no_lock;
		(latch_st == LCH_WAIT) && !rst_edge |=> !mode_valid_o;
	endproperty
	a_no_edge_no_lock: assert property (p_no_edge_no_lock) else $error("Locked early.");

	property p_wake;
		locked && wake_role_select_i |=> gpio_pads_o.oe[STRAP_HI]
			&& gpio_pads_o.out[STRAP_HI] == $past(wake_hit);
	endproperty
	a_wake: assert property (p_wake) else $error("Wake pin wrong.");

	property p_mic;
		locked && mic_role_select_i |=> mic_analog_in_en_o && !gpio_pads_o.oe[MIC_PIN];
	endproperty
	a_mic: assert property (p_mic) else $error("Mic role wrong.");

	property p_slot_default;
		slot_delay_cfg_i == 2'b00 |=> slot_sel_o == SLOT_DEFAULT;
	endproperty
	a_slot_default: assert property (p_slot_default) else $error("Slot not default.");

	property p_secondary_input;
		mode_valid_o && (mode_o == MODE_SEC_ID01 || mode_o == MODE_SEC_ID10)
			|=> !link_pads_o.bclk_oe && !link_pads_o.sync_oe;
	endproperty
	a_secondary_input: assert property (p_secondary_input) else $error("Pin driven.");

	property p_sync_dir;
		mode_valid_o ##1 mode_valid_o |-> link_pads_o.sync_oe == $past(mode_o == MODE_DSP);
	endproperty
	a_sync_dir: assert property (p_sync_dir) else $error("Sync direction wrong.");

	property p_pin_reset_keeps;
		mode_valid_o && !rpin_s |=> mode_o == $past(mode_o);
	endproperty
	a_pin_reset_keeps: assert property (p_pin_reset_keeps) else $error("Pin cleared mode.");

	c_primary: cover property (mode_valid_o && mode_o == MODE_PRI && link_pads_o.bclk_oe);
	c_dsp:     cover property (mode_valid_o && mode_o == MODE_DSP);
	c_wake:    cover property (gpio_pads_o.oe[STRAP_HI] && gpio_pads_o.out[STRAP_HI]);
	c_slot:    cover property (slot_hit_o);

endmodule : smg_top

// ===== sim/smg_link_host.sv
// Behavioural link controller that supplies bit clock and frame sync in secondary modes.
`timescale 1ns/100ps
module smg_link_host (
	// Control and observation.
	input  wire logic run_i,
	input  wire logic hit_i,
	output logic      busy_o,
	output int        hit_bits_o,
	// Link pins.
	output logic      bit_clk_o,
	output logic      sync_o
);

	// ------------------------------------------------------------------
	// Frame generator
	// ------------------------------------------------------------------
	// One frame of 256 bits per rise of run_i; clock stands still low between frames.
	initial begin
		bit_clk_o = 1'b0;
		sync_o = 1'b0;
		busy_o = 1'b0;
		hit_bits_o = 0;
		forever begin
			@(posedge run_i);
			busy_o = 1'b1;
			hit_bits_o = 0;
			for (int b = 0; b < 256; b++) begin
				sync_o = (b < 16);
				#400 bit_clk_o = 1'b1;
				if (hit_i === 1'b1) begin
					hit_bits_o++;
				end
				#400 bit_clk_o = 1'b0;
			end
			sync_o = 1'b0;
			busy_o = 1'b0;
		end
	end

endmodule : smg_link_host

// ===== sim/tb.sv
// Self-checking bench of the strap mode latch, GPIO roles and link pin control.
`timescale 1ns/100ps
module tb;
	import smg_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic           clk_i, rst_b_i, reset_pin_b_i, crystal_in_ok_i;
	logic [7:0]     gpio_in_i, gpio_dir_i, gpio_data_i, gpio_pu_en_i;
	logic [7:0]     wake_mask_i, wake_level_i, gpio_read_o, tb_en, tb_val;
	logic           wake_role_select_i, monitor_role_select_i, mic_role_select_i;
	logic           monitor_out_i, bit_clk_i, sync_i, host_bclk, host_sync;
	logic [1:0]     slot_delay_cfg_i, codec_id_o;
	smg_gpio_pads_t gpio_pads_o;
	smg_link_pads_t link_pads_o;
	smg_mode_t      mode_o;
	logic           mode_valid_o, mic_analog_in_en_o, crystal_needed_o, slot_hit_o;
	logic [3:0]     slot_sel_o;
	logic           host_run, host_busy;
	int             hit_bits, failures, checked, bclk_rises;
	integer         seed;
	int             codes [4] = '{0, 3, 1, 2};
	typedef struct { int sel; logic [15:0] exp; logic [15:0] msk; } smg_note_t;
	smg_note_t      notes [$];
	event           chk_ev;
	string          names [14] = '{"mode_o", "mode_valid_o", "codec_id_o", "pads_oe",
		"pads_pu", "pads_out", "bclk_oe", "sync_oe", "crystal_needed_o", "slot_sel_o",
		"mic_analog_in_en_o", "gpio_read_o", "hit_bits", "bclk_rises"};

	// ------------------------------------------------------------------
	// Pin resolution and instances
	// ------------------------------------------------------------------
	assign gpio_in_i = (gpio_pads_o.oe & gpio_pads_o.out) | (~gpio_pads_o.oe & tb_en & tb_val)
		| (~gpio_pads_o.oe & ~tb_en & gpio_pads_o.pu);
	assign bit_clk_i = link_pads_o.bclk_oe ? link_pads_o.bclk_out : host_bclk;
	assign sync_i    = link_pads_o.sync_oe ? link_pads_o.sync_out : host_sync;

	smg_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reset_pin_b_i(reset_pin_b_i),
		.gpio_in_i(gpio_in_i), .gpio_dir_i(gpio_dir_i), .gpio_data_i(gpio_data_i),
		.gpio_pu_en_i(gpio_pu_en_i), .wake_mask_i(wake_mask_i), .wake_level_i(wake_level_i),
		.wake_role_select_i(wake_role_select_i), .monitor_role_select_i(monitor_role_select_i),
		.mic_role_select_i(mic_role_select_i), .monitor_out_i(monitor_out_i),
		.slot_delay_cfg_i(slot_delay_cfg_i), .crystal_in_ok_i(crystal_in_ok_i),
		.bit_clk_i(bit_clk_i), .sync_i(sync_i), .gpio_pads_o(gpio_pads_o),
		.link_pads_o(link_pads_o), .gpio_read_o(gpio_read_o), .mode_o(mode_o),
		.mode_valid_o(mode_valid_o), .codec_id_o(codec_id_o),
		.mic_analog_in_en_o(mic_analog_in_en_o), .crystal_needed_o(crystal_needed_o),
		.slot_sel_o(slot_sel_o), .slot_hit_o(slot_hit_o));

	smg_link_host u_host (.run_i(host_run), .hit_i(slot_hit_o), .busy_o(host_busy),
		.hit_bits_o(hit_bits), .bit_clk_o(host_bclk), .sync_o(host_sync));

	// ------------------------------------------------------------------
	// Clock, helpers and result monitor
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Counts rising edges of the bit clock that the block drives.
	always @(posedge link_pads_o.bclk_out) begin
		bclk_rises++;
	end

	function automatic logic [15:0] obs(input int sel);
		case (sel)
			0:       obs = 16'(mode_o);
			1:       obs = 16'(mode_valid_o);
			2:       obs = 16'(codec_id_o);
			3:       obs = 16'(gpio_pads_o.oe);
			4:       obs = 16'(gpio_pads_o.pu);
			5:       obs = 16'(gpio_pads_o.out);
			6:       obs = 16'(link_pads_o.bclk_oe);
			7:       obs = 16'(link_pads_o.sync_oe);
			8:       obs = 16'(crystal_needed_o);
			9:       obs = 16'(slot_sel_o);
			10:      obs = 16'(mic_analog_in_en_o);
			11:      obs = 16'(gpio_read_o);
			12:      obs = 16'(hit_bits);
			default: obs = 16'(bclk_rises);
		endcase
	endfunction : obs

	task automatic chk(input int sel, input logic [15:0] exp, input logic [15:0] msk);
		notes.push_back('{sel, exp, msk});
		-> chk_ev;
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask : step

	task automatic wrap_up();
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	initial begin
		smg_note_t   n;
		logic [15:0] got;
		forever begin
			@(chk_ev);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				got = obs(n.sel);
				checked++;
				if ((got & n.msk) !== (n.exp & n.msk)) begin
					failures++;
					$display("FAIL %s expected %h seen %h", names[n.sel], n.exp & n.msk,
						got & n.msk);
				end
			end
		end
	end

	initial begin
		#2_000_000;
		failures++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Power cycle with strap levels
	// ------------------------------------------------------------------
	task automatic power_up(input logic [1:0] straps, input logic float_pins);
		rst_b_i = 1'b0;
		reset_pin_b_i = 1'b0;
		crystal_in_ok_i = 1'b0;
		tb_en = float_pins ? 8'h00 : 8'h0C;
		tb_val = {4'h0, straps, 2'h0};
		gpio_dir_i = 8'($random(seed));
		gpio_pu_en_i = 8'($random(seed));
		step(6);
		rst_b_i = 1'b1;
		step(4);
		chk(3, 16'h0000, 16'h00FF);
		chk(4, 16'h00FF, 16'h00FF);
		chk(1, 16'h0000, 16'h0001);
		reset_pin_b_i = 1'b1;
		step(5);
	endtask : power_up

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		seed = 32'h8F84;
		failures = 0;
		checked = 0;
		bclk_rises = 0;
		gpio_data_i = 8'($random(seed));
		wake_mask_i = 8'h00;
		wake_level_i = 8'h00;
		wake_role_select_i = 1'b0;
		monitor_role_select_i = 1'b0;
		mic_role_select_i = 1'b0;
		monitor_out_i = 1'b0;
		slot_delay_cfg_i = 2'b00;
		host_run = 1'b0;
		foreach (codes[i]) begin
			power_up(2'(codes[i]), codes[i] == 3);
			chk(0, 16'(codes[i]), 16'h0003);
			chk(1, 16'h0001, 16'h0001);
			if (codes[i] != 0) begin
				chk(2, 16'(3 - codes[i]), 16'h0003);
			end
			chk(6, 16'h0000, 16'h0001);
			crystal_in_ok_i = 1'b1;
			step(4);
			chk(6, 16'(codes[i] == 3 || codes[i] == 0), 16'h0001);
			chk(7, 16'(codes[i] == 0), 16'h0001);
			chk(8, 16'(codes[i] == 3 || codes[i] == 0), 16'h0001);
			bclk_rises = 0;
			step(10);
			chk(13, 16'((codes[i] == 3 || codes[i] == 0) ? 10 / (2 * BCLK_HALF_CNT) : 0),
				16'h00FF);
			tb_en = 8'h0C;
			tb_val = {4'h0, ~2'(codes[i]), 2'h0};
			reset_pin_b_i = 1'b0;
			step(4);
			reset_pin_b_i = 1'b1;
			step(5);
			chk(0, 16'(codes[i]), 16'h0003);
			chk(1, 16'h0001, 16'h0001);
		end
		for (int k = 0; k < 4; k++) begin
			gpio_dir_i = 8'($random(seed));
			gpio_data_i = 8'($random(seed));
			gpio_pu_en_i = 8'($random(seed));
			tb_en = ~gpio_dir_i;
			tb_val = 8'($random(seed));
			step(4);
			chk(3, 16'(gpio_dir_i), 16'h00FF);
			chk(5, 16'(gpio_data_i), 16'(gpio_dir_i));
			chk(4, 16'(gpio_pu_en_i), 16'h00FF);
			chk(11, 16'(tb_val), 16'(~gpio_dir_i));
		end
		gpio_dir_i = 8'h00;
		tb_en = 8'hE7;
		tb_val = 8'h03;
		wake_mask_i = 8'h21;
		wake_level_i = 8'h01;
		wake_role_select_i = 1'b1;
		monitor_role_select_i = 1'b1;
		mic_role_select_i = 1'b1;
		monitor_out_i = 1'b1;
		step(5);
		chk(3, 16'h0018, 16'h0018);
		chk(5, 16'h0018, 16'h0018);
		chk(10, 16'h0001, 16'h0001);
		chk(11, 16'h0000, 16'h0002);
		chk(8, 16'h0001, 16'h0001);
		tb_val = 8'h22;
		monitor_out_i = 1'b0;
		step(5);
		chk(5, 16'h0000, 16'h0018);
		for (int s = 0; s < 4; s++) begin
			slot_delay_cfg_i = 2'(s);
			step(2);
			chk(9, (s == 1) ? 16'h000A : (s == 2) ? 16'h000B : 16'h0005, 16'h000F);
		end
		host_run = 1'b1;
		step(1);
		host_run = 1'b0;
		for (int t = 0; t < 3000 && host_busy; t++) begin
			step(1);
		end
		if (host_busy !== 1'b0) begin
			failures++;
			$display("FAIL host_busy expected 0 seen %b", host_busy);
		end
		chk(12, 16'h0014, 16'hFFFF);
		step(1);
		wrap_up();
	end

endmodule : tb
